// >>> src/uoc_consts.svh
// Controller constants
`ifndef UOC_CONSTS_SVH
`define UOC_CONSTS_SVH
// ----------------------------------------
// Register indexes
// ----------------------------------------
`define UOC_R_TOPFLAG 4'h0
`define UOC_R_TOPEN 4'h1
`define UOC_R_ERRFLAG 4'h2
`define UOC_R_ERREN 4'h3
`define UOC_R_CTRL 4'h4
`define UOC_R_DUAL 4'h5
`define UOC_R_PWR 4'h6
`define UOC_R_EP0 4'h7
`define UOC_R_ADDR 4'h8
`define UOC_R_TOKEN 4'h9
`define UOC_RST_REG 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define UOC_BD_OWN 15
`define UOC_BD_DTS 14
`define UOC_BD_TCHK 11
`define UOC_BD_HALT 10
`define UOC_F_ERR 1
`define UOC_F_DONE 3
`define UOC_F_ATTACH 6
`define UOC_F_HALT 7
`define UOC_E_TOGGLE 0
`define UOC_E_OVER 1
`define UOC_C_EN 0
`define UOC_C_HOST 3
`define UOC_C_BRST 4
`define UOC_C_JST 7
`define UOC_D_DMPD 4
`define UOC_D_DPPD 5
`define UOC_D_DMPU 6
`define UOC_D_DPPU 7
`define UOC_P_PWR 0
`define UOC_EP_LS 7
`define UOC_A_LS 7
// ----------------------------------------
// Packet identifiers and timing
// ----------------------------------------
`define UOC_PID_OUT 4'h1
`define UOC_PID_IN 4'h9
`define UOC_PID_SETUP 4'hD
`define UOC_PID_ACK 4'h2
`define UOC_PID_NAK 4'hA
`define UOC_PID_STALL 4'hE
`define UOC_SOF_LOAD 14'd12000
`define UOC_BIT_MHZ 8'd12
`define UOC_CLK_MHZ 8'd200
`endif

// >>> src/uoc_pkg.sv
// Controller types
package uoc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RDBD = 3'b001,
      ST_EVAL = 3'b011,
      ST_MOVE = 3'b010,
      ST_WRBD = 3'b110,
      ST_HSK = 3'b111
   } uoc_state_t;
endpackage : uoc_pkg

// >>> src/uoc_fifo.sv
// Valid/ready data buffer
`timescale 1ns/1ps
`default_nettype none
module uoc_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
      step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : step

   assign in_ready = (cnt != (AW+1)'(DEPTH));
   assign out_valid = (cnt != '0);
   assign out_data = mem[rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         if (push) wp <= step(wp);
         if (pop) rp <= step(rp);
         if (push & ~pop) cnt <= cnt + 1'b1;
         else if (pop & ~push) cnt <= cnt - 1'b1;
      end
   end
endmodule : uoc_fifo
`default_nettype wire

// >>> src/uoc_bd_mem.sv
// Descriptor status word memory
`timescale 1ns/1ps
`default_nettype none
module uoc_bd_mem #(
   parameter int AW = 5,
   parameter int DW = 16
) (
   input wire logic clk,
   // CPU port
   input wire logic [AW-1:0] a_addr,
   input wire logic a_we,
   input wire logic [DW-1:0] a_wdata,
   output logic [DW-1:0] a_rdata,
   // Engine port, wins collisions
   input wire logic [AW-1:0] b_addr,
   input wire logic b_we,
   input wire logic [DW-1:0] b_wdata,
   output logic [DW-1:0] b_rdata
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk) begin
      if (a_we) mem[a_addr] <= a_wdata;
      if (b_we) mem[b_addr] <= b_wdata;
      a_rdata <= mem[a_addr];
      b_rdata <= mem[b_addr];
   end
endmodule : uoc_bd_mem
`default_nettype wire

// >>> src/uoc_core.sv
// On-the-go descriptor and mode controller
//
// Function
// - Core-owned descriptor: other fields ignored, except toggle bit for the automatic status packet
// - Module-owned descriptor kept until module releases
// - Received toggle checked only with checking enabled; sent toggle always follows bit
// - Toggle mismatch discards packet when checking enabled
// - Halt bit in device mode: stall, descriptor unchanged, flag set; ignored in host mode
// - Byte count limits, then holds actual count
// - All sources share one interrupt output
// - Enabled error flags set error summary
// - Flags hardware set, cleared by writing one
// - Device control status phase answered automatically
// - IN token sends buffer, updates, flags done
// - OUT token fills buffer, updates, flags done
// - Host transfers always use endpoint zero
// - Host enable unlocks host-only control bits
// - Host frame markers from 12000, stoppable
// - In host mode, SE0 to J or K transition raises attach flag
`timescale 1ns/1ps
`default_nettype none
`include "uoc_consts.svh"
module uoc_core
   import uoc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Control register port
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // CPU descriptor port
   input wire logic [4:0] bd_addr,
   input wire logic bd_wr,
   input wire logic [15:0] bd_wdata,
   output logic [15:0] bd_rdata,
   // Received tokens
   input wire logic tok_valid,
   input wire logic [3:0] tok_pid,
   input wire logic [3:0] tok_ep,
   // Received data
   input wire logic rx_valid,
   output logic rx_ready,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   input wire logic rx_zlp,
   input wire logic rx_data1,
   // Data to send
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [7:0] tx_data,
   output logic tx_last,
   output logic tx_data1,
   output logic tx_zlp,
   // Handshake to send
   output logic hs_valid,
   output logic [3:0] hs_pid,
   // Host token to send
   output logic htok_valid,
   output logic [3:0] htok_pid,
   output logic [3:0] htok_ep,
   output logic [6:0] htok_addr,
   output logic htok_low_speed,
   // Buffer memory access
   output logic [4:0] dma_index,
   output logic [9:0] dma_offset,
   input wire logic dma_rd_valid,
   output logic dma_rd_ready,
   input wire logic [7:0] dma_rd_data,
   output logic dma_wr_valid,
   input wire logic dma_wr_ready,
   output logic [7:0] dma_wr_data,
   // Bus pins
   input wire logic dp_in,
   input wire logic dm_in,
   output logic dp_out,
   output logic dm_out,
   output logic dp_oe_n,
   output logic dm_oe_n,
   output logic dp_pullup,
   output logic dm_pullup,
   output logic dp_pulldown,
   output logic dm_pulldown,
   output logic sof_pulse,
   output logic usb_irq
);
   uoc_state_t state;
   logic [7:0] top_flag, top_en, err_flag, err_en, ctrl, dual, pwr, ep0, addr;
   logic [7:0] top_view;
   logic [4:0] bd_idx;
   logic [3:0] cur_pid, cur_ep;
   logic [15:0] word, eb_rdata, eb_wdata;
   logic [9:0] cnt;
   logic is_tx, mv_drop, mv_auto, status_pend;
   logic ev_done, ev_halt, ev_tog, ev_over, ev_attach;
   logic host, dev_act, host_go, eb_we;
   logic rbv, rb_take, rb_last, rb_zlp, rb_d1, rb_bad, wr_byte, rd_fire;
   logic [7:0] rb_data;
   logic [10:0] rb_word;
   logic txb_ready;
   logic [8:0] txb_out;
   logic dp_s1, dp_s2, dm_s1, dm_s2, prev_se0;
   logic [7:0] acc;
   logic [13:0] frame_cnt;

   assign host = ctrl[`UOC_C_HOST];
   assign dev_act = ctrl[`UOC_C_EN] & pwr[`UOC_P_PWR] & ~host;
   // Token refused while busy
   assign host_go = reg_wr & (reg_addr == `UOC_R_TOKEN) & host & (state == ST_IDLE);

   // ----------------------------------------
   // Descriptor memory and data buffers
   // ----------------------------------------
   uoc_bd_mem #(.AW(5), .DW(16)) u_mem (
      .clk(clk),
      .a_addr(bd_addr),
      .a_we(bd_wr),
      .a_wdata(bd_wdata),
      .a_rdata(bd_rdata),
      .b_addr(bd_idx),
      .b_we(eb_we),
      .b_wdata(eb_wdata),
      .b_rdata(eb_rdata)
   );

   uoc_fifo #(.W(11), .DEPTH(2)) u_rxb (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data({rx_data1, rx_zlp, rx_last, rx_data}),
      .out_valid(rbv),
      .out_ready(rb_take),
      .out_data(rb_word)
   );

   uoc_fifo #(.W(9), .DEPTH(2)) u_txb (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(rd_fire),
      .in_ready(txb_ready),
      .in_data({cnt == word[9:0] - 10'd1, dma_rd_data}),
      .out_valid(tx_valid),
      .out_ready(tx_ready),
      .out_data(txb_out)
   );

   assign tx_data = txb_out[7:0];
   assign tx_last = txb_out[8];
   assign rb_data = rb_word[7:0];
   assign rb_last = rb_word[8];
   assign rb_zlp = rb_word[9];
   assign rb_d1 = rb_word[10];

   // ----------------------------------------
   // Data movement
   // ----------------------------------------
   assign rb_bad = word[`UOC_BD_TCHK] & (rb_d1 != word[`UOC_BD_DTS]) & ~mv_auto;
   assign wr_byte = (state == ST_MOVE) & ~is_tx & rbv & ~mv_drop & ~mv_auto & ~rb_bad
                  & ~rb_zlp & (cnt != word[9:0]);
   assign dma_wr_valid = wr_byte;
   assign dma_wr_data = rb_data;
   // Unstored bytes still drain
   assign rb_take = (state == ST_MOVE) & ~is_tx & rbv & (~wr_byte | dma_wr_ready);
   assign dma_rd_ready = (state == ST_MOVE) & is_tx & txb_ready & (cnt != word[9:0]);
   assign rd_fire = dma_rd_ready & dma_rd_valid;
   assign dma_index = bd_idx;
   assign dma_offset = cnt;
   // Release with actual count
   assign eb_we = (state == ST_WRBD);
   assign eb_wdata = {1'b0, word[`UOC_BD_DTS], cur_pid, cnt};
   assign hs_valid = (state == ST_HSK);

   // ----------------------------------------
   // Transfer engine
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         bd_idx <= '0;
         cur_pid <= '0;
         cur_ep <= '0;
         word <= '0;
         cnt <= '0;
         is_tx <= 1'b0;
         mv_drop <= 1'b0;
         mv_auto <= 1'b0;
         status_pend <= 1'b0;
         hs_pid <= '0;
         htok_valid <= 1'b0;
         tx_zlp <= 1'b0;
         tx_data1 <= 1'b0;
         ev_done <= 1'b0;
         ev_halt <= 1'b0;
         ev_tog <= 1'b0;
         ev_over <= 1'b0;
      end else begin
         htok_valid <= 1'b0;
         tx_zlp <= 1'b0;
         ev_done <= 1'b0;
         ev_halt <= 1'b0;
         ev_tog <= 1'b0;
         ev_over <= 1'b0;
         case (state)
            ST_IDLE: begin
               mv_drop <= 1'b0;
               mv_auto <= 1'b0;
               cnt <= '0;
               if (host_go) begin
                  // All targets via endpoint zero
                  cur_pid <= reg_wdata[7:4];
                  cur_ep <= reg_wdata[3:0];
                  is_tx <= (reg_wdata[7:4] != `UOC_PID_IN);
                  bd_idx <= {4'h0, reg_wdata[7:4] != `UOC_PID_IN};
                  state <= ST_RDBD;
               end else if (dev_act & tok_valid) begin
                  cur_pid <= tok_pid;
                  cur_ep <= tok_ep;
                  is_tx <= (tok_pid == `UOC_PID_IN);
                  bd_idx <= {tok_ep, tok_pid == `UOC_PID_IN};
                  state <= ST_RDBD;
               end
            end
            ST_RDBD: begin
               state <= ST_EVAL;
            end
            ST_EVAL: begin
               word <= eb_rdata;
               tx_data1 <= eb_rdata[`UOC_BD_DTS];
               if (!eb_rdata[`UOC_BD_OWN]) begin
                  // Owner bit, and toggle bit for automatic status packet
                  word <= '0;
                  if (host) begin
                     state <= ST_IDLE;
                  end else if (status_pend && cur_ep == 4'h0 && cur_pid != `UOC_PID_SETUP) begin
                     mv_auto <= 1'b1;
                     if (is_tx) begin
                        tx_zlp <= 1'b1;
                        status_pend <= 1'b0;
                        state <= ST_IDLE;
                     end else begin
                        state <= ST_MOVE;
                     end
                  end else begin
                     hs_pid <= `UOC_PID_NAK;
                     mv_drop <= 1'b1;
                     state <= is_tx ? ST_HSK : ST_MOVE;
                  end
               end else if (eb_rdata[`UOC_BD_HALT] && !host) begin
                  // Descriptor left untouched
                  hs_pid <= `UOC_PID_STALL;
                  ev_halt <= 1'b1;
                  mv_drop <= 1'b1;
                  state <= is_tx ? ST_HSK : ST_MOVE;
               end else begin
                  htok_valid <= host;
                  if (is_tx && eb_rdata[9:0] == 10'd0) begin
                     tx_zlp <= 1'b1;
                     state <= ST_WRBD;
                  end else begin
                     state <= ST_MOVE;
                  end
               end
            end
            ST_MOVE: begin
               if (is_tx) begin
                  if (rd_fire) begin
                     cnt <= cnt + 10'd1;
                     if (cnt + 10'd1 == word[9:0]) state <= ST_WRBD;
                  end
               end else if (rb_take) begin
                  if (wr_byte) cnt <= cnt + 10'd1;
                  if (!mv_drop && !mv_auto && !rb_bad && !rb_zlp && cnt == word[9:0]) begin
                     ev_over <= 1'b1;
                  end
                  if (rb_last) begin
                     if (mv_drop) begin
                        state <= ST_HSK;
                     end else if (mv_auto) begin
                        hs_pid <= `UOC_PID_ACK;
                        status_pend <= 1'b0;
                        state <= ST_HSK;
                     end else if (rb_bad) begin
                        ev_tog <= 1'b1;
                        state <= ST_IDLE;
                     end else begin
                        hs_pid <= `UOC_PID_ACK;
                        state <= ST_WRBD;
                     end
                  end
               end
            end
            ST_WRBD: begin
               ev_done <= 1'b1;
               if (!host) status_pend <= (cur_pid == `UOC_PID_SETUP);
               // Host software acknowledges
               state <= (!is_tx && !host) ? ST_HSK : ST_IDLE;
            end
            ST_HSK: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Flags and enables
   // ----------------------------------------
   function automatic logic [7:0] clr_mask(input logic [3:0] idx);
      clr_mask = (reg_wr && reg_addr == idx) ? reg_wdata[7:0] : 8'h00;
   endfunction : clr_mask

   assign ev_attach = host & prev_se0 & (dp_s2 ^ dm_s2);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         top_flag <= `UOC_RST_REG;
         err_flag <= `UOC_RST_REG;
      end else begin
         // Set beats same-cycle clear
         top_flag <= (top_flag & ~clr_mask(`UOC_R_TOPFLAG))
                   | ({7'h00, ev_done} << `UOC_F_DONE)
                   | ({7'h00, ev_halt} << `UOC_F_HALT)
                   | ({7'h00, ev_attach} << `UOC_F_ATTACH);
         err_flag <= (err_flag & ~clr_mask(`UOC_R_ERRFLAG))
                   | ({7'h00, ev_tog} << `UOC_E_TOGGLE)
                   | ({7'h00, ev_over} << `UOC_E_OVER);
      end
   end

   always_comb begin
      top_view = top_flag;
      top_view[`UOC_F_ERR] = |(err_flag & err_en);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         usb_irq <= 1'b0;
      end else begin
         usb_irq <= |(top_view & top_en);
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         top_en <= `UOC_RST_REG;
         err_en <= `UOC_RST_REG;
         ctrl <= `UOC_RST_REG;
         dual <= `UOC_RST_REG;
         pwr <= `UOC_RST_REG;
         ep0 <= `UOC_RST_REG;
         addr <= `UOC_RST_REG;
      end else if (reg_wr) begin
         case (reg_addr)
            `UOC_R_TOPEN: top_en <= reg_wdata[7:0];
            `UOC_R_ERREN: err_en <= reg_wdata[7:0];
            `UOC_R_CTRL: begin
               ctrl <= reg_wdata[7:0] & ~(8'h01 << `UOC_C_JST);
               if (!reg_wdata[`UOC_C_HOST]) begin
                  ctrl[`UOC_C_BRST] <= 1'b0;
               end
               if (reg_wdata[`UOC_C_HOST] && !host) begin
                  ctrl[`UOC_C_EN] <= 1'b1;
               end
            end
            `UOC_R_DUAL: dual <= reg_wdata[7:0];
            `UOC_R_PWR: pwr <= reg_wdata[7:0];
            `UOC_R_EP0: begin
               ep0 <= reg_wdata[7:0];
               ep0[`UOC_EP_LS] <= reg_wdata[`UOC_EP_LS] & host;
            end
            `UOC_R_ADDR: begin
               addr <= reg_wdata[7:0];
               addr[`UOC_A_LS] <= reg_wdata[`UOC_A_LS] & host;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else begin
         case (reg_addr)
            `UOC_R_TOPFLAG: reg_rdata <= {8'h00, top_view};
            `UOC_R_TOPEN: reg_rdata <= {8'h00, top_en};
            `UOC_R_ERRFLAG: reg_rdata <= {8'h00, err_flag};
            `UOC_R_ERREN: reg_rdata <= {8'h00, err_en};
            `UOC_R_CTRL: reg_rdata <= {8'h00, dp_s2 & ~dm_s2, ctrl[6:0]};
            `UOC_R_DUAL: reg_rdata <= {8'h00, dual};
            `UOC_R_PWR: reg_rdata <= {8'h00, pwr};
            `UOC_R_EP0: reg_rdata <= {8'h00, ep0};
            `UOC_R_ADDR: reg_rdata <= {8'h00, addr};
            `UOC_R_TOKEN: reg_rdata <= {8'h00, cur_pid, cur_ep};
            default: reg_rdata <= '0;
         endcase
      end
   end

   // ----------------------------------------
   // Host token, pins and frame timing
   // ----------------------------------------
   assign htok_pid = cur_pid;
   assign htok_ep = cur_ep;
   assign htok_addr = addr[6:0];
   assign htok_low_speed = ep0[`UOC_EP_LS];
   assign dp_out = 1'b0;
   assign dm_out = 1'b0;
   // Bus reset drives SE0
   assign dp_oe_n = ~(host & ctrl[`UOC_C_BRST]);
   assign dm_oe_n = dp_oe_n;
   assign dp_pullup = dual[`UOC_D_DPPU];
   assign dm_pullup = dual[`UOC_D_DMPU];
   assign dp_pulldown = dual[`UOC_D_DPPD];
   assign dm_pulldown = dual[`UOC_D_DMPD];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dp_s1 <= 1'b0;
         dp_s2 <= 1'b0;
         dm_s1 <= 1'b0;
         dm_s2 <= 1'b0;
         prev_se0 <= 1'b0;
      end else begin
         dp_s1 <= dp_in;
         dp_s2 <= dp_s1;
         dm_s1 <= dm_in;
         dm_s2 <= dm_s1;
         prev_se0 <= ~dp_s2 & ~dm_s2;
      end
   end

   // Fractional step keeps bit rate exact
   always_ff @(posedge clk) begin
      if (sys_rst || !(host && ctrl[`UOC_C_EN])) begin
         acc <= '0;
         frame_cnt <= `UOC_SOF_LOAD;
         sof_pulse <= 1'b0;
      end else begin
         sof_pulse <= 1'b0;
         if (acc + `UOC_BIT_MHZ >= `UOC_CLK_MHZ) begin
            acc <= acc + `UOC_BIT_MHZ - `UOC_CLK_MHZ;
            if (frame_cnt == 14'd1) begin
               frame_cnt <= `UOC_SOF_LOAD;
               sof_pulse <= 1'b1;
            end else begin
               frame_cnt <= frame_cnt - 14'd1;
            end
         end else begin
            acc <= acc + `UOC_BIT_MHZ;
         end
      end
   end
endmodule : uoc_core
`default_nettype wire

// >>> testbench/uoc_core_sva.sv
// Port checker
`timescale 1ns/1ps
`default_nettype none
`include "uoc_consts.svh"
module uoc_core_sva (
   // Watched ports
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic hs_valid,
   input wire logic [3:0] hs_pid,
   input wire logic dma_wr_valid,
   input wire logic [7:0] dma_wr_data,
   input wire logic dp_out,
   input wire logic dp_oe_n,
   input wire logic dm_oe_n,
   input wire logic dp_pullup,
   input wire logic dp_pulldown
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_hs_code: assert property (hs_valid |-> hs_pid == `UOC_PID_ACK ||
      hs_pid == `UOC_PID_NAK || hs_pid == `UOC_PID_STALL) else $error("bad hs");
   a_hs_pulse: assert property (hs_valid |=> !hs_valid) else $error("long hs");
   a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("tx dropped");
   a_pull_map: assert property (reg_wr && reg_addr == `UOC_R_DUAL |=>
      dp_pullup == $past(reg_wdata[7]) && dp_pulldown == $past(reg_wdata[5]))
      else $error("pull map");
   a_oe_pair: assert property (dp_oe_n == dm_oe_n) else $error("oe split");
   a_dp_low: assert property (!dp_out) else $error("dp high");
   a_rdata_high: assert property (reg_rdata[15:8] == 8'h00) else $error("high byte");
   a_wr_path: assert property (dma_wr_valid |-> !tx_valid && !hs_valid)
      else $error("wr path");
   c_stall: cover property (hs_valid && hs_pid == `UOC_PID_STALL);
   c_nak: cover property (hs_valid && hs_pid == `UOC_PID_NAK);
   c_tx: cover property (tx_valid && tx_ready);
endmodule : uoc_core_sva
bind uoc_core uoc_core_sva u_uoc_core_sva (.*);
`default_nettype wire

// >>> testbench/uoc_host_model.sv
// Far-side bus partner model
`timescale 1ns/1ps
`default_nettype none
module uoc_host_model (
   // Clock
   input wire logic clk,
   // Toward the block
   output logic tok_valid,
   output logic [3:0] tok_pid,
   output logic [3:0] tok_ep,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_last,
   output logic rx_zlp,
   output logic rx_data1,
   output logic tx_ready,
   output logic dp_in,
   output logic dm_in,
   // From the block
   input wire logic rx_ready
);
   initial begin
      {tok_valid, tok_pid, tok_ep, rx_valid, rx_last, rx_zlp, rx_data1} = '0;
      {rx_data, tx_ready, dp_in, dm_in} = '0;
   end
   // Stall every other cycle
   always @(posedge clk) begin
      tx_ready <= #1 ~tx_ready;
   end
   task automatic token(input logic [3:0] p, input logic [3:0] e);
      {tok_valid, tok_pid, tok_ep} = {1'b1, p, e};
      @(posedge clk);
      #1;
      tok_valid = 1'b0;
   endtask : token
   task automatic send(input int n, input logic d1);
      for (int i = 0; i < n; i++) begin
         {rx_valid, rx_data, rx_last, rx_data1} = {1'b1, 8'(8'h30 + i), i == n - 1, d1};
         for (int k = 0; k < 64 && !rx_ready; k++) begin
            @(posedge clk);
            #1;
         end
         @(posedge clk);
         #1;
      end
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask : send
endmodule : uoc_host_model
`default_nettype wire

// >>> testbench/tb_uoc_core.sv
// Self-checking bench
`timescale 1ns/1ps
`default_nettype none
`include "uoc_consts.svh"
module tb_uoc_core;
   logic clk, sys_rst, reg_wr, bd_wr, dma_rd_valid, dma_wr_ready, rx_ready, tx_valid, tx_last;
   logic tok_valid, rx_valid, rx_last, rx_zlp, rx_data1, tx_ready, tx_data1, tx_zlp, hs_valid;
   logic htok_valid, htok_low_speed, dma_rd_ready, dma_wr_valid, dp_in, dm_in, dp_out, dm_out;
   logic dp_oe_n, dm_oe_n, dp_pullup, dm_pullup, dp_pulldown, dm_pulldown, sof_pulse, usb_irq;
   logic [3:0] reg_addr, tok_pid, tok_ep, hs_pid, htok_pid, htok_ep, seen_hs;
   logic [4:0] bd_addr, dma_index;
   logic [6:0] htok_addr;
   logic [7:0] rx_data, tx_data, dma_rd_data, dma_wr_data, seen_tx;
   logic [9:0] dma_offset;
   logic [15:0] reg_wdata, reg_rdata, bd_wdata, bd_rdata;
   logic hs_seen, seen_d1;
   int failures = 0;
   int n_compared = 0;
   int k;
   uoc_core u_uoc_core (.*);
   uoc_host_model u_uoc_host_model (.*);
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (hs_valid) begin
         seen_hs <= hs_pid;
         hs_seen <= 1'b1;
      end
      if (tx_valid && tx_ready) begin
         seen_tx <= tx_data;
         seen_d1 <= tx_data1;
      end
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] e);
      n_compared++;
      if (seen !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", s, e, seen);
      end
   endtask : chk
   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict
   task automatic bail;
      failures++;
      print_verdict();
   endtask : bail
   // b selects the descriptor port
   task automatic wr(input bit b, input logic [4:0] a, input logic [15:0] d);
      if (b) {bd_addr, bd_wdata, bd_wr} = {a, d, 1'b1};
      else {reg_addr, reg_wdata, reg_wr} = {a[3:0], d, 1'b1};
      @(posedge clk);
      #1;
      {reg_wr, bd_wr} = 2'b00;
   endtask : wr
   task automatic rd(input bit b, input logic [4:0] a, input logic [15:0] e);
      {reg_addr, bd_addr} = {a[3:0], a};
      @(posedge clk);
      #1;
      chk($sformatf("%s%0h", b ? "desc" : "reg", a), b ? bd_rdata : reg_rdata, e);
   endtask : rd
   task automatic wait_hs(input logic [3:0] e);
      wait_flag(-1);
      chk("handshake", 16'(seen_hs), 16'(e));
      hs_seen = 1'b0;
   endtask : wait_hs
   task automatic wait_flag(input int n);
      reg_addr = 4'h0;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (k < 200 && (n < 0 ? hs_seen : reg_rdata[n]) !== 1'b1);
      if ((n < 0 ? hs_seen : reg_rdata[n]) !== 1'b1) bail();
   endtask : wait_flag
   initial begin
      {sys_rst, reg_wr, bd_wr, dma_rd_valid, dma_wr_ready, hs_seen} = 6'b100000;
      {reg_addr, reg_wdata, bd_addr, bd_wdata, dma_rd_data} = '0;
      repeat (6) @(posedge clk);
      #1;
      {sys_rst, dma_rd_valid, dma_wr_ready, dma_rd_data} = {3'b011, 8'h5C};
      rd(0, 5'h00, 16'h0000);
      rd(0, 5'h04, 16'h0000);
      $display("test reset done");
      wr(0, 5'h04, 16'h0002);
      wr(0, 5'h04, 16'h0000);
      wr(0, 5'h01, 16'h0000);
      wr(0, 5'h03, 16'h0000);
      wr(0, 5'h00, 16'h00FF);
      wr(0, 5'h02, 16'h00FF);
      wr(0, 5'h04, 16'h0011);
      rd(0, 5'h04, 16'h0001);
      wr(0, 5'h05, 16'h0004);
      wr(0, 5'h07, 16'h0009);
      wr(0, 5'h06, 16'h0001);
      wr(0, 5'h05, 16'h0084);
      chk("pullup", 16'(dp_pullup), 16'h0001);
      wr(0, 5'h01, 16'h008A);
      wr(0, 5'h03, 16'h0001);
      $display("test device init done");
      wr(1, 5'h03, 16'hC002);
      u_uoc_host_model.token(`UOC_PID_IN, 4'h1);
      wait_flag(3);
      rd(1, 5'h03, 16'h6402);
      chk("tx byte", 16'({seen_d1, seen_tx}), 16'h015C);
      chk("irq", 16'(usb_irq), 16'h0001);
      wr(0, 5'h00, 16'h0000);
      rd(0, 5'h00, 16'h0008);
      wr(0, 5'h00, 16'h0008);
      rd(0, 5'h00, 16'h0000);
      u_uoc_host_model.token(`UOC_PID_IN, 4'h1);
      wait_hs(`UOC_PID_NAK);
      wr(1, 5'h03, 16'h8402);
      u_uoc_host_model.token(`UOC_PID_IN, 4'h1);
      wait_hs(`UOC_PID_STALL);
      rd(1, 5'h03, 16'h8402);
      rd(0, 5'h00, 16'h0080);
      wr(0, 5'h00, 16'h0080);
      $display("test in tokens done");
      // Toggle differs, checking off: kept
      wr(1, 5'h04, 16'h8003);
      u_uoc_host_model.token(`UOC_PID_OUT, 4'h2);
      u_uoc_host_model.send(2, 1'b1);
      wait_hs(`UOC_PID_ACK);
      rd(1, 5'h04, 16'h0402);
      rd(0, 5'h00, 16'h0008);
      wr(0, 5'h00, 16'h0008);
      wr(1, 5'h04, 16'h8803);
      u_uoc_host_model.token(`UOC_PID_OUT, 4'h2);
      u_uoc_host_model.send(2, 1'b1);
      wait_flag(1);
      rd(0, 5'h02, 16'h0001);
      rd(1, 5'h04, 16'h8803);
      chk("no handshake", 16'(hs_seen), 16'h0000);
      chk("irq", 16'(usb_irq), 16'h0001);
      wr(0, 5'h02, 16'h0001);
      rd(0, 5'h00, 16'h0000);
      $display("test out tokens done");
      wr(0, 5'h04, 16'h0008);
      rd(0, 5'h04, 16'h0009);
      wr(0, 5'h05, 16'h0030);
      wr(0, 5'h01, 16'h0040);
      u_uoc_host_model.dp_in = 1'b1;
      wait_flag(6);
      chk("irq", 16'(usb_irq), 16'h0001);
      repeat (8) @(posedge clk);
      rd(0, 5'h04, 16'h0089);
      wr(0, 5'h04, 16'h0019);
      rd(0, 5'h04, 16'h0099);
      chk("oe", 16'(dp_oe_n), 16'h0000);
      wr(0, 5'h04, 16'h0009);
      wr(1, 5'h00, 16'h0000);
      wr(0, 5'h09, 16'h0090);
      rd(0, 5'h09, 16'h0090);
      $display("test host done");
      print_verdict();
   end
endmodule : tb_uoc_core
`default_nettype wire
